// ---- hw/tcmc_top.sv ----
`timescale 1ns/10ps
// Summary of operation
// - After reset, run automatic mode: convert every 800 ms, partial power-down between.
// - In automatic mode a one-shot write starts a conversion right after the write.
// - After an automatic-mode one-shot conversion, the 800 ms schedule restarts, timed from that conversion's start.
// - Conversion ending with no bus access active and no power-down write in that cycle loads the temperature register.
// - Conversion ending during a recognised bus access leaves the temperature register unchanged.
// - Conversions may start during bus access; result loads only if access ended.
// - Writing the full power-down bit enters full power-down at once, stopping conversions.
// - In full power-down a one-shot write powers up 4 ms, converts, then sleeps.
// - The serial interface keeps working in full power-down: reads and writes.
// - After that one-shot, stay down until power-down cleared or one-shot set again.
// - Automatic conversion takes 4 us wake-up plus 25 us converting.
// - Configuration resets to 40h with power-down and one-shot bits clear.
// - Register pointer resets to select the temperature register.
module tcmc_top
  import tcmc_pkg::*;
#(
  parameter int PERIOD_CYCLES = PERIOD_CYC,
  parameter int PWRUP_CYCLES = PWRUP_CYC,
  parameter int PER_W = 26,
  parameter int TIM_W = 18
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire tcmc_wr_t bus_wr,
  input wire logic bus_active,
  input wire logic [RES_W-1:0] adc_result,
  output logic [RES_W-1:0] temp_value,
  output logic [7:0] cfg_value,
  output logic [7:0] pointer,
  output tcmc_stat_t stat
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tcmc_state_t state;
  tcmc_state_t next_state;
  logic [RES_W-1:0] adc_s;
  logic [TIM_W-1:0] timer;
  logic [PER_W-1:0] per_cnt;
  logic wr_cfg;
  logic pd_req;
  logic os_pend;
  logic launch;
  logic conv_end;

  // Converter output is asynchronous to the clock
  tcmc_sync #(.W(RES_W)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din(adc_result),
    .dout(adc_s)
  );

  // ****************************************************************
  // Serial-side register writes
  // ****************************************************************
  assign wr_cfg = bus_wr.data_wr && (bus_wr.ptr == PTR_CFG);
  assign pd_req = wr_cfg && bus_wr.data[CFG_PD_BIT];
  assign os_pend = cfg_value[CFG_OS_BIT];
  assign launch = os_pend && !pd_req && ((state == ST_IDLE) || (state == ST_FULLPD));
  assign conv_end = (state == ST_CONV) && (timer == '0);

  // Pointer register, live in every power state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pointer <= PTR_RESET;
    end else if (bus_wr.ptr_wr || bus_wr.data_wr) begin
      pointer <= bus_wr.ptr;
    end
  end

  // Configuration register; a write wins over the self-clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_value <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg_value <= bus_wr.data;
    end else if (launch) begin
      cfg_value[CFG_OS_BIT] <= 1'b0;
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  // Next state
  always_comb begin
    next_state = state;
    if (pd_req) begin
      next_state = ST_FULLPD;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (os_pend || (per_cnt == '0)) begin
            next_state = ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (timer == '0) begin
            next_state = ST_CONV;
          end
        end
        ST_CONV: begin
          if (timer == '0) begin
            next_state = cfg_value[CFG_PD_BIT] ? ST_FULLPD : ST_IDLE;
          end
        end
        ST_FULLPD: begin
          if (os_pend) begin
            next_state = ST_PWRUP;
          end else if (!cfg_value[CFG_PD_BIT]) begin
            next_state = ST_IDLE;
          end
        end
        ST_PWRUP: begin
          if (timer == '0) begin
            next_state = ST_CONV;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Phase timer, loaded on each state entry
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer <= '0;
    end else if (next_state != state) begin
      unique case (next_state)
        ST_WAKE: timer <= TIM_W'(WAKE_CYC - 1);
        ST_CONV: timer <= TIM_W'(CONV_CYC - 1);
        ST_PWRUP: timer <= TIM_W'(PWRUP_CYCLES - 1);
        default: timer <= '0;
      endcase
    end else if (timer != '0) begin
      timer <= timer - 1'b1;
    end
  end

  // Period counter, restarted at each conversion start
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      per_cnt <= PER_W'(PERIOD_CYCLES - 1);
    end else if ((state == ST_IDLE) && (next_state == ST_WAKE)) begin
      per_cnt <= PER_W'(PERIOD_CYCLES - 1);
    end else if ((state == ST_FULLPD) || (state == ST_PWRUP)) begin
      per_cnt <= PER_W'(PERIOD_CYCLES - 1);
    end else if (per_cnt != '0) begin
      per_cnt <= per_cnt - 1'b1;
    end
  end

  // ****************************************************************
  // Result register with bus-access guard
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      temp_value <= '0;
    end else if (conv_end && !pd_req && !bus_active) begin
      temp_value <= adc_s;
    end
  end

  // Status outputs, registered from the next-state decode
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stat <= '0;
    end else begin
      stat.full_pd <= (next_state == ST_FULLPD);
      stat.partial_pd <= (next_state == ST_IDLE);
      stat.waking <= (next_state == ST_WAKE) || (next_state == ST_PWRUP);
      stat.converting <= (next_state == ST_CONV);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_PD_IMMEDIATE: assert property (@(posedge clock) disable iff (!rst_n)
    pd_req |=> (state == ST_FULLPD) ##1 (state != ST_WAKE))
    else $error("power-down write did not stop conversions");

  AST_OS_AUTO: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_cfg && bus_wr.data[CFG_OS_BIT] && !bus_wr.data[CFG_PD_BIT] && state == ST_IDLE)
    |=> ##1 (state == ST_WAKE))
    else $error("one-shot write in automatic mode did not start a conversion");

  AST_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    (conv_end && !pd_req && !bus_active) |=> (temp_value == $past(adc_s)))
    else $error("finished conversion not loaded");

  AST_BLOCK: assert property (@(posedge clock) disable iff (!rst_n)
    (conv_end && bus_active) |=> $stable(temp_value))
    else $error("result loaded during bus access");

  AST_ONLY_AT_END: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(conv_end) |-> $stable(temp_value))
    else $error("temperature changed outside conversion end");

  AST_PD_RETURN: assert property (@(posedge clock) disable iff (!rst_n)
    (conv_end && cfg_value[CFG_PD_BIT] && !wr_cfg) |=> (state == ST_FULLPD))
    else $error("one-shot in power-down did not return to sleep");

  AST_PWRUP_LEN: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_FULLPD && next_state == ST_PWRUP)
    |=> (timer == TIM_W'(PWRUP_CYCLES - 1)) && (state == ST_PWRUP))
    else $error("power-up time wrong");

  AST_CONV_LEN: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_WAKE && timer == '0 && !pd_req)
    |=> (state == ST_CONV) && (timer == TIM_W'(CONV_CYC - 1)))
    else $error("conversion phase timing wrong");

  AST_PERIOD: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_IDLE && per_cnt == '0 && !pd_req) |=> (state == ST_WAKE)
      && (per_cnt == PER_W'(PERIOD_CYCLES - 1)))
    else $error("periodic conversion not started");

  AST_OS_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
    (launch && !wr_cfg) |=> !cfg_value[CFG_OS_BIT])
    else $error("one-shot bit not cleared after launch");

  AST_PTR_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    (bus_wr.ptr_wr && state == ST_FULLPD) |=> (pointer == $past(bus_wr.ptr)))
    else $error("pointer write lost in power-down");

endmodule // tcmc_top

// ---- hw/tcmc_pkg.sv ----
package tcmc_pkg;

  // ****************************************************************
  // Timebase
  // ****************************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int PERIOD_MS = 800;
  localparam int PWRUP_MS = 4;
  localparam int CONV_US = 25;
  localparam int WAKE_US = 4;
  // Exact divisions at 50 MHz, so no rounding is needed
  localparam int PERIOD_CYC = (CLK_HZ / 1000) * PERIOD_MS;
  localparam int PWRUP_CYC = (CLK_HZ / 1000) * PWRUP_MS;
  localparam int CONV_CYC = (CLK_HZ / 1_000_000) * CONV_US;
  localparam int WAKE_CYC = (CLK_HZ / 1_000_000) * WAKE_US;

  // ****************************************************************
  // Register pointer and configuration layout
  // ****************************************************************
  localparam logic [7:0] PTR_TEMP = 8'h00;
  localparam logic [7:0] PTR_CFG = 8'h01;
  localparam logic [7:0] PTR_RESET = PTR_TEMP;
  localparam logic [7:0] CFG_RESET = 8'h40;
  localparam int CFG_PD_BIT = 7;
  localparam int CFG_OS_BIT = 2;
  localparam int RES_W = 10;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Write from the serial interface: pointer byte, optional data byte
  typedef struct packed {
    logic ptr_wr;
    logic data_wr;
    logic [7:0] ptr;
    logic [7:0] data;
  } tcmc_wr_t;

  // Power and conversion status
  typedef struct packed {
    logic full_pd;
    logic partial_pd;
    logic waking;
    logic converting;
  } tcmc_stat_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAKE = 3'b001,
    ST_CONV = 3'b010,
    ST_FULLPD = 3'b011,
    ST_PWRUP = 3'b100
  } tcmc_state_t;

endpackage

// ---- hw/tcmc_sync.sv ----
`timescale 1ns/10ps
module tcmc_sync #(
  parameter int W = 10
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;

  // Two flip-flop synchroniser for a level from outside the clock domain
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // tcmc_sync

// ---- tb/tcmc_host.sv ----
`timescale 1ns/10ps
// ****
// Serial master model
// ****
module tcmc_host
  import tcmc_pkg::*;
(
  input wire logic clock,
  output tcmc_wr_t bus_wr,
  output logic bus_active
);
  // Bus idle at time zero
  initial begin
    bus_wr = '0;
    bus_active = 1'b0;
  end
  // Access level, changed only by the caller at a falling edge
  task automatic set_active(input logic v);
    bus_active = v;
  endtask
  // One strobe for one cycle; released bytes show inverted values
  task automatic write_reg(input logic dat, input logic [7:0] ptr, input logic [7:0] data);
    @(negedge clock);
    bus_wr = '{ptr_wr: !dat, data_wr: dat, ptr: ptr, data: data};
    @(negedge clock);
    bus_wr = '{ptr_wr: 1'b0, data_wr: 1'b0, ptr: ~ptr, data: ~data};
  endtask
endmodule // tcmc_host

// ---- tb/temp_conversion_mode_control_bench.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
// ****
// Bench top
// ****
module temp_conversion_mode_control_bench;
  import tcmc_pkg::*;
  localparam int PER = 2000;
  localparam int PWR = 50;
  localparam int GAP = PER - WAKE_CYC - CONV_CYC;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [RES_W-1:0] adc_result = '0;
  logic [RES_W-1:0] old_temp;
  logic [RES_W-1:0] adc_val;
  tcmc_wr_t bus_wr;
  logic bus_active;
  logic [RES_W-1:0] temp_value;
  logic [7:0] cfg_value;
  logic [7:0] pointer;
  tcmc_stat_t stat;
  int fail_count = 0;
  int checks_done = 0;
  int n;
  // Clock of 20 ns
  always #10 clock = ~clock;
  tcmc_host i_tcmc_host (.clock(clock), .bus_wr(bus_wr), .bus_active(bus_active));
  tcmc_top #(.PERIOD_CYCLES(PER), .PWRUP_CYCLES(PWR)) i_tcmc_top (
    .clock(clock), .rst_n(rst_n), .bus_wr(bus_wr), .bus_active(bus_active),
    .adc_result(adc_result), .temp_value(temp_value), .cfg_value(cfg_value),
    .pointer(pointer), .stat(stat));
  // Access active at conversion end keeps the old value
  function automatic logic [RES_W-1:0] exp_temp(int mode, logic [RES_W-1:0] o,
                                               logic [RES_W-1:0] v);
    return (mode == 1) ? o : v;
  endfunction
  // Counts and verdict, then stop
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Bounded wait for a status bit, counting falling edges
  task automatic wait_bit(input int idx, input logic val, input int bound, output int cnt);
    cnt = 0;
    while (stat[idx] !== val) begin
      @(negedge clock);
      cnt++;
      if (cnt > bound) begin
        fail_count++;
        $display("Error status bit %0d expected %b seen %b", idx, val, stat[idx]);
        give_verdict();
      end
    end
  endtask
  // Watch for any conversion activity over a span
  task automatic quiet(input int cycles);
    int seen;
    seen = 0;
    repeat (cycles) begin
      @(negedge clock);
      if (stat.waking !== 1'b0 || stat.converting !== 1'b0) seen++;
    end
    `CHK("activity in power-down", 0, seen)
  endtask
  // One conversion; mode 0 quiet bus, 1 access at end, 2 access at start
  task automatic auto_cycle(input int mode, input int gap);
    i_tcmc_host.set_active(mode == 2);
    wait_bit(1, 1'b1, PER + 10, n);
    if (gap >= 0) `CHK("start spacing", gap, n)
    wait_bit(1, 1'b0, WAKE_CYC + 5, n);
    `CHK("wake length", WAKE_CYC, n)
    adc_val = RES_W'($urandom);
    adc_result = adc_val;
    old_temp = temp_value;
    i_tcmc_host.set_active(mode == 1);
    wait_bit(0, 1'b0, CONV_CYC + 5, n);
    `CHK("conversion length", CONV_CYC, n)
    `CHK("temp value", exp_temp(mode, old_temp, adc_val), temp_value)
    i_tcmc_host.set_active(1'b0);
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h37f3129a));
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    `CHK("config after reset", CFG_RESET, cfg_value)
    `CHK("pointer after reset", PTR_TEMP, pointer)
    @(negedge clock);
    `CHK("status after reset", 4'b0100, stat)
    auto_cycle(0, -1);
    for (int i = 0; i < 6; i++) begin
      auto_cycle((i < 3) ? i : int'($urandom_range(2)), GAP);
    end
    repeat (300) @(negedge clock);
    i_tcmc_host.write_reg(1'b1, PTR_CFG, 8'h44);
    auto_cycle(0, 1);
    `CHK("one-shot cleared", CFG_RESET, cfg_value)
    auto_cycle(1, GAP);
    i_tcmc_host.write_reg(1'b1, PTR_CFG, 8'h80);
    wait_bit(3, 1'b1, 3, n);
    `CHK("power-down entry", 0, n)
    quiet(PER + 500);
    i_tcmc_host.write_reg(1'b0, PTR_TEMP, 8'h00);
    `CHK("pointer in power-down", PTR_TEMP, pointer)
    i_tcmc_host.write_reg(1'b1, PTR_TEMP, 8'hff);
    `CHK("config after other write", 8'h80, cfg_value)
    adc_val = RES_W'($urandom);
    adc_result = adc_val;
    i_tcmc_host.write_reg(1'b1, PTR_CFG, 8'h84);
    `CHK("pointer after write", PTR_CFG, pointer)
    wait_bit(3, 1'b0, 4, n);
    wait_bit(0, 1'b1, PWR + 5, n);
    `CHK("power-up length", PWR, n)
    wait_bit(0, 1'b0, CONV_CYC + 5, n);
    `CHK("conversion length", CONV_CYC, n)
    `CHK("back to power-down", 4'b1000, stat)
    `CHK("temp value", adc_val, temp_value)
    quiet(PER + 500);
    `CHK("one-shot cleared", 8'h80, cfg_value)
    i_tcmc_host.write_reg(1'b1, PTR_CFG, 8'h00);
    wait_bit(3, 1'b0, 4, n);
    auto_cycle(0, -1);
    give_verdict();
  end
endmodule // temp_conversion_mode_control_bench
